// ### hdl/cmm_pkg.sv
/*
 * Constants for the carrier modulator timing block: register indices, control bit positions,
 * reset values and timing counts.
 * Assumes a 100 MHz core clock that stands in for the oscillator.
 */
// Contract
// (RULE1) FSK mark lasts mark buffer plus one carrier periods, space lasts space buffer periods.
// (RULE2) Divide-by-two bit doubles every mark and space duration.
// (RULE3) Extended space turns the next loaded period into pure space of mark plus space.
// (RULE4) Later periods stay pure space while extended space stays enabled.
// (RULE5) Clearing extended space resumes mark then space at the next period.
// (RULE6) Extended space unit is 8 oscillator clocks in time mode, carrier periods in FSK.
// (RULE7) End-of-cycle flag sets when the counter reloads from the mark buffer.
// (RULE8) Interrupt request on flag set only if interrupt enable was already set; here a pending flag requests as soon as enable is set.
// (RULE9) Space buffer copies to active space register at every cycle end.
// (RULE10) Flag clears on status read followed by low mark or space access, and on reset.
// (RULE11) Software clears the flag in its service routine when interrupts are enabled.
// (RULE12) Mark buffer written in the service routine applies to the following period.
// (RULE13) Divide-by-two set clocks the transmitter at bus rate, clear at oscillator rate.
// (RULE14) External interrupt mask bit set masks external pin and keyscan interrupts.
// (RULE15) Baseband bit disables the carrier and holds the carrier output high.
// (RULE16) Mode bit selects FSK when 1 and time mode when 0; reset clears it.
// (RULE17) Software leaves baseband and mode bits alone during a transmission.
// (RULE18) Setting master enable initialises and starts the carrier and modulator clocks.
// (RULE19) Clearing master enable finishes the cycle, stops clocks, forces output low.
// (RULE20) Software initialises data and control registers before setting master enable.
// (RULE21) Twelve-bit buffers sit in three byte registers: nibbles, mark low, space low.
// (RULE22) Twelve-bit down counter; underflow closes gate; complement match to space reopens.
// (RULE23) Time mode counts oscillator divided by 8; mark is buffer plus one units.
// (RULE24) FSK swaps primary and secondary carrier pairs each time the mark expires.
// (RULE25) Upper nibbles register holds mark nibble in bits 7..4, space nibble in 3..0.
// (RULE26) Flag is read only; status writes leave it, other control bits read/write.
package cmm_pkg;
	localparam logic [1:0] CMM_IDX_CSR = 2'h0;
	localparam logic [1:0] CMM_IDX_NIB = 2'h1;
	localparam logic [1:0] CMM_IDX_MLO = 2'h2;
	localparam logic [1:0] CMM_IDX_SLO = 2'h3;
	localparam int CMM_B_EN = 0;
	localparam int CMM_B_IE = 1;
	localparam int CMM_B_MODE = 2;
	localparam int CMM_B_BASEBAND_BIT = 3;
	localparam int CMM_B_EXSP = 4;
	localparam int CMM_B_EIM = 5;
	localparam int CMM_B_DIVIDE_BY_TWO_BIT = 6;
	localparam int CMM_B_EOC = 7;
	localparam logic [7:0] CMM_CSR_RST = 8'h00;
	localparam logic [7:0] CMM_CSR_WMASK = 8'h7F;
	localparam logic [7:0] CMM_DATA_RST = 8'h00;
	localparam int CMM_CNT_W = 12;
	localparam int CMM_TIME_DIV = 8;
	localparam logic [2:0] CMM_TIME_LAST = 3'h7;
endpackage

// ### hdl/cmm_modulator.sv
/*
 * Modulator timing block: control/status and period registers, 12-bit mark/space
 * counter, time and FSK modes, extended space, end-of-cycle flag and request.
 * Assumes the carrier generator is outside; its output arrives as a level on a pin.
 */
`timescale 1ns/10ps
module cmm_modulator
	import cmm_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Carrier generator side
	input wire logic carrier_i,
	output logic carrier_run_o,
	output logic carrier_div_en_o,
	output logic carrier_sel_o,
	output logic carrier_baseband_bit_o,
	// Outputs
	output logic mod_gate_o,
	output logic mod_out_o,
	output logic eoc_irq_o,
	output logic ext_irq_mask_o
);
	import cmm_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] csr_r;
	logic [7:0] nib_r;
	logic [7:0] mlo_r;
	logic [7:0] slo_r;
	logic eoc_r;
	logic armed_r;
	logic [7:0] rdata_r;
	logic [11:0] cnt_r;
	logic [11:0] active_space_register_r;
	logic in_space_r;
	logic run_r;
	logic exsp_act_r;
	logic sel_r;
	logic divide_by_two_bit_tgl_r;
	logic [2:0] pre_r;
	logic car_s1_r;
	logic car_s2_r;
	logic car_d_r;

	wire logic en_bit = csr_r[CMM_B_EN];
	wire logic ie_bit = csr_r[CMM_B_IE];
	wire logic fsk_bit = csr_r[CMM_B_MODE];
	wire logic baseband_bit_bit = csr_r[CMM_B_BASEBAND_BIT];
	wire logic exsp_bit = csr_r[CMM_B_EXSP];
	wire logic divide_by_two_bit_bit = csr_r[CMM_B_DIVIDE_BY_TWO_BIT];
	wire logic [11:0] mark_buf = {nib_r[7:4], mlo_r}; // see (RULE21) see (RULE25)
	wire logic [11:0] space_buf = {nib_r[3:0], slo_r}; // see (RULE21) see (RULE25)

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire logic wr_csr = wr_i && (addr_i == CMM_IDX_CSR);
	wire logic wr_nib = wr_i && (addr_i == CMM_IDX_NIB);
	wire logic wr_mlo = wr_i && (addr_i == CMM_IDX_MLO);
	wire logic wr_slo = wr_i && (addr_i == CMM_IDX_SLO);
	wire logic rd_csr = rd_i && (addr_i == CMM_IDX_CSR);
	wire logic lo_acc = (wr_i || rd_i) && ((addr_i == CMM_IDX_MLO) || (addr_i == CMM_IDX_SLO));
	wire logic [7:0] csr_view = {eoc_r, csr_r[6:0]};
	wire logic [7:0] rd_mux = (addr_i == CMM_IDX_CSR) ? csr_view :
		(addr_i == CMM_IDX_NIB) ? nib_r :
		(addr_i == CMM_IDX_MLO) ? mlo_r : slo_r;

	// ------------------------------------------------------------
	// Count tick
	// ------------------------------------------------------------
	// Carrier pin is asynchronous; edge taken after the second stage
	wire logic car_rise = car_s2_r && !car_d_r;
	// Divide-by-two halves every count rate, doubling all durations
	wire logic div_ok = !divide_by_two_bit_bit || divide_by_two_bit_tgl_r; // see (RULE2) see (RULE13)
	wire logic time_tick = (pre_r == CMM_TIME_LAST) && div_ok; // see (RULE23) see (RULE6)
	wire logic fsk_tick = car_rise; // see (RULE1) see (RULE6)
	wire logic tick = run_r && (fsk_bit ? fsk_tick : time_tick); // see (RULE16)

	// Space ends when the complement of the decremented counter equals the active space value
	wire logic [11:0] cnt_dec = cnt_r - 12'h001;
	wire logic underflow = !in_space_r && (cnt_r == 12'h000);
	wire logic space_hit = in_space_r && ((~cnt_dec) == active_space_register_r); // see (RULE22)
	wire logic space_zero = underflow && (active_space_register_r == 12'h000);
	wire logic cyc_end = tick && (space_hit || space_zero); // see (RULE7)
	wire logic mark_end = tick && underflow && !exsp_act_r; // see (RULE24)

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			csr_r <= CMM_CSR_RST; // see (RULE14) see (RULE15) see (RULE16)
			nib_r <= CMM_DATA_RST;
			mlo_r <= CMM_DATA_RST;
			slo_r <= CMM_DATA_RST;
			rdata_r <= 8'h00;
		end else begin
			if (wr_csr) begin
				csr_r <= wdata_i & CMM_CSR_WMASK; // see (RULE26)
			end
			if (wr_nib) begin
				nib_r <= wdata_i;
			end
			if (wr_mlo) begin
				mlo_r <= wdata_i; // see (RULE12)
			end
			if (wr_slo) begin
				slo_r <= wdata_i;
			end
			rdata_r <= rd_i ? rd_mux : 8'h00;
		end
	end

	// Flag: set wins over a clear in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eoc_r <= 1'b0; // see (RULE10)
			armed_r <= 1'b0;
		end else begin
			if (cyc_end) begin
				eoc_r <= 1'b1; // see (RULE7)
			end else if (armed_r && lo_acc) begin
				eoc_r <= 1'b0; // see (RULE10)
			end
			if (rd_csr) begin
				armed_r <= 1'b1;
			end else if (lo_acc) begin
				armed_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Modulator counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 12'h000;
			active_space_register_r <= 12'h000;
			in_space_r <= 1'b0;
			run_r <= 1'b0;
			exsp_act_r <= 1'b0;
			sel_r <= 1'b0;
			divide_by_two_bit_tgl_r <= 1'b0;
			pre_r <= 3'h0;
			car_s1_r <= 1'b0;
			car_s2_r <= 1'b0;
			car_d_r <= 1'b0;
		end else begin
			car_s1_r <= carrier_i;
			car_s2_r <= car_s1_r;
			car_d_r <= car_s2_r;
			divide_by_two_bit_tgl_r <= run_r ? !divide_by_two_bit_tgl_r : 1'b0;
			if (!run_r) begin
				pre_r <= 3'h0;
			end else if (div_ok) begin
				pre_r <= pre_r + 3'h1;
			end
			if (!run_r && en_bit) begin
				// Start from a fresh period with both buffers loaded
				run_r <= 1'b1; // see (RULE18)
				cnt_r <= mark_buf;
				active_space_register_r <= space_buf;
				in_space_r <= exsp_bit;
				exsp_act_r <= exsp_bit;
				sel_r <= 1'b0;
			end else if (cyc_end) begin
				cnt_r <= mark_buf; // see (RULE12)
				active_space_register_r <= space_buf; // see (RULE9)
				// Whole period turns to space while the bit stays set
				in_space_r <= exsp_bit; // see (RULE3) see (RULE4) see (RULE5)
				exsp_act_r <= exsp_bit;
				run_r <= en_bit; // see (RULE19)
			end else if (tick) begin
				cnt_r <= cnt_dec;
				if (underflow) begin
					in_space_r <= 1'b1; // see (RULE22)
				end
			end
			if (mark_end && fsk_bit) begin
				sel_r <= !sel_r; // see (RULE24)
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	wire logic gate = run_r && !in_space_r;
	// Baseband keeps the carrier high so the gate alone shapes the output
	wire logic car_lvl = baseband_bit_bit ? 1'b1 : car_s2_r; // see (RULE15)

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_out_o <= 1'b0;
			mod_gate_o <= 1'b0;
		end else begin
			mod_gate_o <= gate;
			mod_out_o <= gate && car_lvl; // see (RULE19)
		end
	end

	assign rdata_o = rdata_r;
	assign carrier_run_o = run_r; // see (RULE18)
	assign carrier_div_en_o = div_ok; // see (RULE13)
	assign carrier_sel_o = sel_r;
	assign carrier_baseband_bit_o = baseband_bit_bit;
	assign eoc_irq_o = eoc_r && ie_bit; // see (RULE8)
	assign ext_irq_mask_o = csr_r[CMM_B_EIM]; // see (RULE14)

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_EOC_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE7)
		cyc_end |=> eoc_r) else $error("flag not set at cycle end");
	AST_EOC_CLR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE10)
		(armed_r && lo_acc && !cyc_end) |=> !eoc_r) else $error("flag not cleared");
	AST_EOC_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE26)
		(wr_csr && eoc_r) |=> eoc_r) else $error("csr write touched flag");
	AST_IRQ: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE8)
		(cyc_end && ie_bit && !wr_csr) |=> eoc_irq_o) else $error("no request");
	AST_ACTIVE_SPACE_REGISTER: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE9)
		(cyc_end && run_r) |=> (active_space_register_r == $past(space_buf))) else $error("space not copied");
	AST_EXSP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE4)
		exsp_act_r |=> !mod_gate_o) else $error("mark in extended space");
	AST_TIME: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE23)
		(run_r && !fsk_bit && !divide_by_two_bit_bit && time_tick) |=> !time_tick [*7])
		else $error("time unit not 8");
	AST_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE19)
		!run_r |=> !mod_out_o) else $error("output not low when stopped");

	// ------------------------------------------------------------
	// Register port checks
	// ------------------------------------------------------------
	AST_RD_CSR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE26)
		rd_csr |=> (rdata_o == {$past(eoc_r), $past(csr_r[6:0])}))
		else $error("status read wrong");
	AST_RD_NIB: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE25)
		(rd_i && (addr_i == CMM_IDX_NIB)) |=> (rdata_o == $past(nib_r)))
		else $error("nibble read wrong");
	AST_RD_MLO: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE21)
		(rd_i && (addr_i == CMM_IDX_MLO)) |=> (rdata_o == $past(mlo_r)))
		else $error("mark low read wrong");
	AST_RD_SLO: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE21)
		(rd_i && (addr_i == CMM_IDX_SLO)) |=> (rdata_o == $past(slo_r)))
		else $error("space low read wrong");
	AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE21)
		!rd_i |=> (rdata_o == 8'h00))
		else $error("read data without read");
	AST_WR_NIB: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE25)
		wr_nib |=> (nib_r == $past(wdata_i)))
		else $error("nibble write lost");
	AST_WR_MLO: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE21)
		wr_mlo |=> (mlo_r == $past(wdata_i)))
		else $error("mark low write lost");
	AST_WR_SLO: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE21)
		wr_slo |=> (slo_r == $past(wdata_i)))
		else $error("space low write lost");
	AST_CSR_WR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE26)
		wr_csr |=> (csr_r == ($past(wdata_i) & CMM_CSR_WMASK)))
		else $error("control write wrong");
	AST_BIT7: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE26)
		1'b1 |-> !csr_r[CMM_B_EOC])
		else $error("flag position written");

	// ------------------------------------------------------------
	// Flag checks
	// ------------------------------------------------------------
	AST_FLAG_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE10)
		(eoc_r && !(armed_r && lo_acc)) |=> eoc_r)
		else $error("flag lost without clear");
	AST_FLAG_QUIET: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE7)
		(!eoc_r && !cyc_end) |=> !eoc_r)
		else $error("flag set without cycle end");
	AST_ARM: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE10)
		rd_csr |=> armed_r)
		else $error("status read not noted");
	AST_IRQ_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE8)
		!ie_bit |-> !eoc_irq_o)
		else $error("request while disabled");

	// ------------------------------------------------------------
	// Counter checks
	// ------------------------------------------------------------
	AST_START: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE18)
		(!run_r && en_bit) |=> (run_r && (cnt_r == $past(mark_buf))))
		else $error("start did not load");
	AST_STAY_RUN: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE19)
		(run_r && !cyc_end) |=> run_r)
		else $error("stopped inside a cycle");
	AST_RUN_EN: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE18)
		(cyc_end && en_bit) |=> run_r)
		else $error("stopped while enabled");
	AST_RUN_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE19)
		(cyc_end && !en_bit) |=> !run_r)
		else $error("kept running after disable");
	AST_RELOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE12)
		cyc_end |=> (cnt_r == $past(mark_buf)))
		else $error("mark not reloaded");
	AST_EXSP_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE5)
		cyc_end |=> (in_space_r == $past(exsp_bit)))
		else $error("extended space not taken at load");
	AST_SPACE_ENTER: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE22)
		(tick && underflow && !cyc_end) |=> in_space_r)
		else $error("no space after underflow");
	AST_ACTIVE_SPACE_REGISTER_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE9)
		(run_r && !cyc_end) |=> $stable(active_space_register_r))
		else $error("space register moved mid cycle");
	AST_CNT_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE22)
		(run_r && !tick) |=> $stable(cnt_r))
		else $error("counter moved without tick");
	AST_CNT_DEC: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE22)
		(tick && !cyc_end) |=> (cnt_r == $past(cnt_dec)))
		else $error("counter did not decrement");
	AST_EXSP_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE4)
		(run_r && !cyc_end) |=> $stable(exsp_act_r))
		else $error("extended space changed mid period");

	// ------------------------------------------------------------
	// Output checks
	// ------------------------------------------------------------
	AST_SEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE24)
		(mark_end && fsk_bit) |=> (carrier_sel_o != $past(carrier_sel_o)))
		else $error("pair not swapped");
	AST_SEL_TIME: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE24)
		(run_r && !fsk_bit) |=> $stable(carrier_sel_o))
		else $error("pair swapped in time mode");
	AST_GATE_DLY: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE22)
		run_r |=> (mod_gate_o == $past(gate)))
		else $error("gate output wrong");
	AST_BASEBAND_BIT_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE15)
		(baseband_bit_bit && gate) |=> mod_out_o)
		else $error("baseband mark not high");
	AST_CAR_FOLLOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE15)
		(!baseband_bit_bit && gate) |=> (mod_out_o == $past(car_s2_r)))
		else $error("mark does not follow carrier");
	AST_SPACE_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE22)
		(run_r && in_space_r) |=> !mod_out_o)
		else $error("output high in space");
	AST_GATE_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE19)
		!run_r |=> !mod_gate_o)
		else $error("gate open when stopped");

	// ------------------------------------------------------------
	// Check helpers
	// ------------------------------------------------------------
	// Cycles since the last time unit; bounds the unit length check
	logic [4:0] gap_r;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_r <= 5'h00;
		end else if (!run_r || time_tick) begin
			gap_r <= 5'h00;
		end else if (gap_r != 5'h1F) begin
			gap_r <= gap_r + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// Rate checks
	// ------------------------------------------------------------
	AST_DIV_ALT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE13)
		(run_r && divide_by_two_bit_bit && !wr_csr) |=> (carrier_div_en_o != $past(carrier_div_en_o)))
		else $error("halved rate not alternating");
	AST_DIV_FULL: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE13)
		!divide_by_two_bit_bit |-> carrier_div_en_o)
		else $error("full rate enable dropped");
	AST_PRE_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE23)
		!run_r |=> (pre_r == 3'h0))
		else $error("prescaler not cleared");
	AST_UNIT_MAX: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see (RULE2)
		run_r |-> (gap_r < 5'(2 * CMM_TIME_DIV)))
		else $error("time unit too long");
endmodule

// ### tb/cmm_carrier_model.sv
/*
 * Carrier generator stand-in: a square wave of 2*HALF enabled clocks.
 * Assumes the modulator's run, divide enable and baseband outputs steer it.
 */
`timescale 1ns/10ps
module cmm_carrier_model #(
	parameter int HALF = 4
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Steering
	input wire logic run_i,
	input wire logic div_en_i,
	input wire logic baseband_bit_i,
	// Carrier level
	output logic carrier_o
);
	int cnt_r;
	// Stopped carrier stands low unless baseband holds it high, so no stray edge is counted
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 0;
			carrier_o <= 1'b0;
		end else if (!run_i || baseband_bit_i) begin
			cnt_r <= 0;
			carrier_o <= baseband_bit_i;
		end else if (div_en_i) begin
			cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
			carrier_o <= (cnt_r == HALF - 1) ? ~carrier_o : carrier_o;
		end
	end
endmodule

// ### tb/testbench.sv
/*
 * Self-checking bench for cmm_modulator: registers, timing, flag, enable.
 * Assumes the carrier model on the far side and a 100 MHz clock.
 */
`timescale 1ns/10ps
module testbench;
	import cmm_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_q = 0, s;
	logic [1:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, r0, r1, r2;
	logic [7:0] q[$];
	logic run, div_en, sel, baseband_bit, gate, mout, irq, eim, car;
	int error_cnt = 0, n_tests = 0, cyc = 0, n;
	cmm_modulator DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .carrier_i(car),
		.carrier_run_o(run), .carrier_div_en_o(div_en), .carrier_sel_o(sel),
		.carrier_baseband_bit_o(baseband_bit), .mod_gate_o(gate), .mod_out_o(mout), .eoc_irq_o(irq),
		.ext_irq_mask_o(eim));
	cmm_carrier_model CAR (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(run),
		.div_en_i(div_en), .baseband_bit_i(baseband_bit), .carrier_o(car));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Read notes its expected byte; the monitor compares it a cycle later
	task acc(input logic r, input logic w, input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		rd_i <= r;
		wr_i <= w;
		addr_i <= a;
		wdata_i <= d;
		if (r) begin
			q.push_back(d);
		end
	endtask
	// Counts cycles until the gate shows level v
	task span(input logic v);
		n = 0;
		while (gate !== v && n < 600) begin
			@(negedge mclk_i);
			n++;
		end
	endtask
	task stop;
		acc(0, 1, CMM_IDX_CSR, 8'h00);
		acc(0, 0, 0, 8'h00);
		chk(run, 1);
		n = 0;
		while (run !== 1'b0 && n < 300) begin
			@(negedge mclk_i);
			n++;
		end
		chk(run, 0);
		chk(mout, 0);
	endtask
	task finish_test;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (rd_q) begin
			chk({4'h0, rdata_o}, {4'h0, q.pop_front()});
		end
		rd_q <= rd_i;
		if (cyc > 20000) begin
			chk(12'h1, 12'h0);
			finish_test();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h9eb2));
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) acc(1, 0, i[1:0], CMM_DATA_RST);
		r0 = $urandom;
		r1 = $urandom;
		r2 = $urandom;
		acc(0, 1, CMM_IDX_NIB, r0);
		acc(0, 1, CMM_IDX_MLO, r1);
		acc(0, 1, CMM_IDX_SLO, r2);
		acc(0, 1, CMM_IDX_CSR, 8'hFE);
		acc(1, 0, CMM_IDX_NIB, r0);
		acc(1, 0, CMM_IDX_MLO, r1);
		acc(1, 0, CMM_IDX_SLO, r2);
		acc(1, 0, CMM_IDX_CSR, 8'h7E);
		acc(0, 1, CMM_IDX_NIB, 8'h00);
		acc(0, 0, 0, 8'h00);
		chk(eim, 1);
		chk(baseband_bit, 1);
		acc(0, 1, CMM_IDX_MLO, 8'h03);
		acc(0, 1, CMM_IDX_SLO, 8'h02);
		acc(0, 1, CMM_IDX_CSR, 8'h01);
		acc(0, 0, 0, 8'h00);
		span(1);
		span(0);
		span(1);
		span(0);
		chk(n, 32);
		span(1);
		chk(n, 16);
		repeat (3) @(posedge mclk_i);
		chk(irq, 0);
		acc(1, 0, CMM_IDX_CSR, 8'h81);
		acc(1, 0, CMM_IDX_MLO, 8'h03);
		acc(1, 0, CMM_IDX_CSR, 8'h01);
		acc(0, 1, CMM_IDX_CSR, 8'h03);
		acc(0, 0, 0, 8'h00);
		span(0);
		span(1);
		repeat (3) @(posedge mclk_i);
		chk(irq, 1);
		acc(0, 1, CMM_IDX_MLO, 8'h05);
		acc(0, 1, CMM_IDX_SLO, 8'h01);
		acc(0, 0, 0, 8'h00);
		span(0);
		span(1);
		span(0);
		chk(n, 48);
		span(1);
		chk(n, 8);
		stop();
		acc(0, 1, CMM_IDX_CSR, 8'h41);
		acc(0, 0, 0, 8'h00);
		span(1);
		s = div_en;
		@(negedge mclk_i);
		chk(div_en, !s);
		span(0);
		span(1);
		span(0);
		chk(n, 96);
		span(1);
		chk(n, 16);
		stop();
		acc(0, 1, CMM_IDX_CSR, 8'h11);
		acc(0, 0, 0, 8'h00);
		span(1);
		chk(n, 600);
		acc(0, 1, CMM_IDX_CSR, 8'h01);
		acc(0, 0, 0, 8'h00);
		span(1);
		chk(n < 80, 1);
		stop();
		acc(0, 1, CMM_IDX_CSR, 8'h05);
		acc(0, 0, 0, 8'h00);
		span(1);
		span(0);
		span(1);
		s = sel;
		span(0);
		chk(n, 48);
		span(1);
		chk(n, 8);
		chk(sel, !s);
		finish_test();
	end
endmodule
